// File: core/eof1_pkg.sv
/*
 eof1_pkg: register map, field layout, reset values and timing constants for the
 eof1 point selector. assumes a 250 mhz core clock and a 30 mhz reference for coarse codes.
*/
package eof1_pkg;
	localparam int CLK_MHZ = 250;
	localparam int REF_MHZ = 30;
	localparam logic [7:0] OFS_CORE_CTRL = 8'h40;
	localparam logic [7:0] OFS_FS_OVR = 8'h44;
	localparam logic [7:0] OFS_HS_OVR = 8'h48;
	localparam logic [7:0] OFS_OTG_CONTROL_STATUS = 8'h80;
	localparam logic [7:0] OFS_FRAME_CTRL = 8'h84;
	localparam int COARSE_SEL_LSB = 2;
	localparam int FS_COARSE_LSB = 12;
	localparam int SPEED_LSB = 22;
	localparam logic [1:0] COARSE_SEL_RST = 2'h0;
	localparam logic [2:0] FS_COARSE_RST = 3'h0;
	localparam logic [11:0] FINE_RST = 12'h000;
	localparam logic [1:0] SPEED_HS = 2'h2;
	localparam logic [1:0] SPEED_FS = 2'h0;
	localparam logic [1:0] SPEED_LS = 2'h1;
	// frame lengths in microseconds, converted to core cycles below
	localparam int FS_FRAME_US = 1000;
	localparam int HS_FRAME_US = 125;
	localparam int UNIT_US = 125;
	localparam int FS_FRAME_CYC = FS_FRAME_US * CLK_MHZ;
	localparam int HS_FRAME_CYC = HS_FRAME_US * CLK_MHZ;
	localparam int UNIT_CYC = UNIT_US * CLK_MHZ;
	// coarse eof1 lead in 30 mhz clocks, per speed, code 0..3
	localparam int HS_REF_0 = 540;
	localparam int HS_REF_1 = 360;
	localparam int HS_REF_2 = 180;
	localparam int HS_REF_3 = 720;
	localparam int FS_REF_0 = 1600;
	localparam int FS_REF_1 = 1400;
	localparam int FS_REF_2 = 1200;
	localparam int FS_REF_3 = 21000;
	localparam int CNT_W = 18;
	typedef struct packed {
		logic [1:0] eof_coarse_select;
		logic [2:0] fs_eof_coarse_count;
		logic [11:0] fs_eof_fine_count;
		logic [11:0] hs_eof_fine_count;
		logic [1:0] host_speed_kind;
		logic host_mode;
	} eof_cfg_t;
endpackage

// File: core/eof1_point_select.sv
/*
 eof1_point_select: wishbone classic slave holding the eof1 override registers and
 the host speed report, plus the frame timer that gates new transactions.
 assumes the host link logic supplies speed and host mode, and honours tx_allow_o.
*/
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps
module eof1_point_select
	import eof1_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic host_mode_i,
	input wire logic [1:0] link_speed_i,
	input wire logic tx_request_i,
	output logic tx_allow_o,
	output logic sof_o,
	output logic eof1_reached_o
);
	import eof1_pkg::*;

	logic [1:0] eof_coarse_select_r;
	logic [2:0] fs_eof_coarse_count_r;
	logic [11:0] fs_eof_fine_count_r;
	logic [11:0] hs_eof_fine_count_r;
	logic [1:0] host_speed_kind_r;
	logic timer_run_r;
	logic ack_r;
	logic err_r;
	logic [31:0] rdata_r;
	logic req;
	logic wr;
	logic mapped;
	logic [31:0] rd_mux;
	logic [31:0] wmask;
	logic [CNT_W-1:0] point;
	logic [CNT_W-1:0] frame_len;
	logic quiet;
	eof_cfg_t cfg;

	function automatic logic is_mapped(input logic [7:0] adr);
		is_mapped = (adr == OFS_CORE_CTRL) || (adr == OFS_FS_OVR) || (adr == OFS_HS_OVR)
			|| (adr == OFS_OTG_CONTROL_STATUS) || (adr == OFS_FRAME_CTRL);
	endfunction

	// one wait state: ack on the second edge of the request, dropped the next cycle
	assign req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
	assign mapped = is_mapped(wb_adr_i);
	assign wr = req && wb_we_i && mapped;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
		end
	endgenerate

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ack_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			ack_r <= req && mapped;
			err_r <= req && !mapped;
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_err_o = err_r;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			eof_coarse_select_r <= COARSE_SEL_RST;
			timer_run_r <= 1'b0;
		end else if (wr && wb_adr_i == OFS_CORE_CTRL) begin
			eof_coarse_select_r <= (wb_dat_i[COARSE_SEL_LSB +: 2] & wmask[COARSE_SEL_LSB +: 2])
				| (eof_coarse_select_r & ~wmask[COARSE_SEL_LSB +: 2]);
		end else if (wr && wb_adr_i == OFS_FRAME_CTRL && wb_sel_i[0]) begin
			timer_run_r <= wb_dat_i[0];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			fs_eof_coarse_count_r <= FS_COARSE_RST;
			fs_eof_fine_count_r <= FINE_RST;
		end else if (wr && wb_adr_i == OFS_FS_OVR) begin
			fs_eof_coarse_count_r <= (wb_dat_i[FS_COARSE_LSB +: 3] & wmask[FS_COARSE_LSB +: 3])
				| (fs_eof_coarse_count_r & ~wmask[FS_COARSE_LSB +: 3]);
			fs_eof_fine_count_r <= (wb_dat_i[11:0] & wmask[11:0])
				| (fs_eof_fine_count_r & ~wmask[11:0]);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			hs_eof_fine_count_r <= FINE_RST;
		end else if (wr && wb_adr_i == OFS_HS_OVR) begin
			hs_eof_fine_count_r <= (wb_dat_i[11:0] & wmask[11:0])
				| (hs_eof_fine_count_r & ~wmask[11:0]);
		end
	end

	// speed is held at fs outside host mode; the reserved code is never reported
	always_ff @(posedge core_clk_i) begin
		if (reset_i || !host_mode_i) begin
			host_speed_kind_r <= SPEED_FS;
		end else if (link_speed_i != 2'h3) begin
			host_speed_kind_r <= link_speed_i;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (wb_adr_i)
			OFS_CORE_CTRL: rd_mux[COARSE_SEL_LSB +: 2] = eof_coarse_select_r;
			OFS_FS_OVR: rd_mux = {17'h0_0000, fs_eof_coarse_count_r, fs_eof_fine_count_r};
			OFS_HS_OVR: rd_mux = {20'h0_0000, hs_eof_fine_count_r};
			OFS_OTG_CONTROL_STATUS: rd_mux = {8'h00, host_speed_kind_r, 22'h00_0000};
			OFS_FRAME_CTRL: rd_mux = {30'h0000_0000, quiet, timer_run_r};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (req) begin
			rdata_r <= rd_mux;
		end
	end
	assign wb_dat_o = rdata_r;

	assign cfg = '{eof_coarse_select: eof_coarse_select_r,
		fs_eof_coarse_count: fs_eof_coarse_count_r,
		fs_eof_fine_count: fs_eof_fine_count_r,
		hs_eof_fine_count: hs_eof_fine_count_r,
		host_speed_kind: host_speed_kind_r,
		host_mode: host_mode_i};

	eof_lead_calc u_calc (
		.cfg_i(cfg),
		.point_o(point),
		.frame_len_o(frame_len)
	);

	frame_timer u_timer (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.run_i(timer_run_r && host_mode_i),
		.point_i(point),
		.frame_len_i(frame_len),
		.sof_o(sof_o),
		.quiet_o(quiet)
	);

	// a bad override can only move the eof1 point within the frame; it cannot make the gate leak
	assign tx_allow_o = tx_request_i && timer_run_r && host_mode_i && !quiet;
	assign eof1_reached_o = quiet;

	AST_FS_OVR_POINT: assert property (@(posedge core_clk_i) disable iff (reset_i)
		host_speed_kind_r == SPEED_FS && fs_eof_coarse_count_r == 3'h1
		&& fs_eof_fine_count_r == 12'h000 |-> point == CNT_W'(UNIT_CYC))
		else $error("fs override point wrong");
	AST_FS_COARSE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		host_speed_kind_r == SPEED_FS && {fs_eof_coarse_count_r, fs_eof_fine_count_r} == 15'h0
		&& eof_coarse_select_r == 2'h0
		|-> point == CNT_W'(FS_FRAME_CYC - FS_REF_0 * CLK_MHZ / REF_MHZ))
		else $error("fs coarse point wrong");
	AST_HS_OVR_POINT: assert property (@(posedge core_clk_i) disable iff (reset_i)
		host_speed_kind_r == SPEED_HS && hs_eof_fine_count_r != 12'h000
		|-> point == CNT_W'(hs_eof_fine_count_r))
		else $error("hs override point wrong");
	AST_HS_COARSE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		host_speed_kind_r == SPEED_HS && hs_eof_fine_count_r == 12'h000
		&& eof_coarse_select_r == 2'h2
		|-> point == CNT_W'(HS_FRAME_CYC - HS_REF_2 * CLK_MHZ / REF_MHZ))
		else $error("hs coarse point wrong");
	AST_FS_WRITE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr && wb_adr_i == OFS_FS_OVR && wb_sel_i == 4'hf
		|=> fs_eof_fine_count_r == $past(wb_dat_i[11:0])
		&& fs_eof_coarse_count_r == $past(wb_dat_i[14:12]))
		else $error("fs override write lost");
	AST_HS_READBACK: assert property (@(posedge core_clk_i) disable iff (reset_i)
		req && mapped && !wb_we_i && wb_adr_i == OFS_HS_OVR
		|=> wb_ack_o && wb_dat_o == {20'h0_0000, hs_eof_fine_count_r})
		else $error("hs override readback wrong");
	AST_CSR_RESERVED: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wb_ack_o && $past(wb_adr_i) == OFS_OTG_CONTROL_STATUS |-> wb_dat_o[31:24] == 8'h00
		&& wb_dat_o[23:22] != 2'h3)
		else $error("otg status reserved bits set");
	AST_SPEED_NOT_HOST: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!host_mode_i |=> host_speed_kind_r == SPEED_FS)
		else $error("speed not fs outside host mode");
	AST_NO_TX_QUIET: assert property (@(posedge core_clk_i) disable iff (reset_i)
		quiet |-> !tx_allow_o)
		else $error("transaction allowed after eof1");
endmodule

// File: core/eof_lead_calc.sv
/*
 eof_lead_calc: turns the register settings into the eof1 point, counted in core
 cycles from the start of the frame. assumes the settings are stable between frames.
*/
`timescale 1ns/100ps
module eof_lead_calc
	import eof1_pkg::*;
(
	input wire eof1_pkg::eof_cfg_t cfg_i,
	output logic [eof1_pkg::CNT_W-1:0] point_o,
	output logic [eof1_pkg::CNT_W-1:0] frame_len_o
);
	import eof1_pkg::*;

	function automatic int ref_to_cyc(input int ref_clocks);
		ref_to_cyc = (ref_clocks * CLK_MHZ) / REF_MHZ;
	endfunction

	logic hs;
	int lead;
	int fs_ovr;
	assign hs = (cfg_i.host_speed_kind == SPEED_HS);

	always_comb begin
		fs_ovr = FS_FRAME_CYC - (int'(cfg_i.fs_eof_coarse_count) * UNIT_CYC
			+ int'(cfg_i.fs_eof_fine_count));
		lead = 0;
		if (hs) begin
			if (cfg_i.hs_eof_fine_count != 12'h000) begin
				lead = HS_FRAME_CYC - int'(cfg_i.hs_eof_fine_count);
			end else begin
				unique case (cfg_i.eof_coarse_select)
					2'h0: lead = ref_to_cyc(HS_REF_0);
					2'h1: lead = ref_to_cyc(HS_REF_1);
					2'h2: lead = ref_to_cyc(HS_REF_2);
					2'h3: lead = ref_to_cyc(HS_REF_3);
				endcase
			end
		end else begin
			if ({cfg_i.fs_eof_coarse_count, cfg_i.fs_eof_fine_count} != 15'h0000) begin
				lead = fs_ovr;
			end else begin
				unique case (cfg_i.eof_coarse_select)
					2'h0: lead = ref_to_cyc(FS_REF_0);
					2'h1: lead = ref_to_cyc(FS_REF_1);
					2'h2: lead = ref_to_cyc(FS_REF_2);
					2'h3: lead = ref_to_cyc(FS_REF_3);
				endcase
			end
		end
		// clamp so an oversized setting cannot wrap the point
		if (lead < 1) begin
			lead = 1;
		end
		if (hs) begin
			if (lead > HS_FRAME_CYC) begin
				lead = HS_FRAME_CYC;
			end
			point_o = CNT_W'(HS_FRAME_CYC - lead);
			frame_len_o = CNT_W'(HS_FRAME_CYC);
		end else begin
			if (lead > FS_FRAME_CYC) begin
				lead = FS_FRAME_CYC;
			end
			point_o = CNT_W'(FS_FRAME_CYC - lead);
			frame_len_o = CNT_W'(FS_FRAME_CYC);
		end
	end
endmodule

// File: core/frame_timer.sv
/*
 frame_timer: frame counter, held at zero while run_i is low, that pulses sof and holds a quiet flag
 from the eof1 point to the next sof. assumes point and length come from eof_lead_calc.
*/
`timescale 1ns/100ps
module frame_timer
	import eof1_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic run_i,
	input wire logic [eof1_pkg::CNT_W-1:0] point_i,
	input wire logic [eof1_pkg::CNT_W-1:0] frame_len_i,
	output logic sof_o,
	output logic quiet_o
);
	import eof1_pkg::*;

	logic [CNT_W-1:0] count_r;
	logic quiet_r;
	logic wrap;
	assign wrap = (count_r >= frame_len_i - CNT_W'(1));

	always_ff @(posedge core_clk_i) begin
		if (reset_i || !run_i || wrap) begin
			count_r <= '0;
		end else begin
			count_r <= count_r + CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i || !run_i) begin
			sof_o <= 1'b0;
		end else begin
			sof_o <= wrap;
		end
	end

	// quiet holds from the eof1 point until the next sof clears it
	always_ff @(posedge core_clk_i) begin
		if (reset_i || !run_i || wrap) begin
			quiet_r <= 1'b0;
		end else if (count_r + CNT_W'(1) >= point_i) begin
			quiet_r <= 1'b1;
		end
	end
	assign quiet_o = quiet_r;

	AST_QUIET_UNTIL_SOF: assert property (@(posedge core_clk_i) disable iff (reset_i)
		quiet_r && run_i && !wrap |=> quiet_r)
		else $error("quiet dropped before sof");
	AST_SOF_CLEARS: assert property (@(posedge core_clk_i) disable iff (reset_i)
		run_i && wrap |=> !quiet_r && count_r == '0)
		else $error("frame wrap did not restart");
endmodule

// File: verif/test_usb_host_eof1_point_select.sv
/*
 test_usb_host_eof1_point_select: self-checking bench for eof1_point_select, with a
 register model kept in plain variables and a free-running count of cycles since sof.
 assumes the package constants and a registered one-wait-state wishbone answer.
*/
`timescale 1ns/100ps
module test_usb_host_eof1_point_select;
	import eof1_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic hmode = 1'b1;
	logic treq = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = '0;
	logic [1:0] spd = 2'h3;
	logic [31:0] rdat;
	logic ack, err, allow, sof, eof1;
	logic [31:0] m40 = '0, m44 = '0, m48 = '0;
	logic [1:0] m_spd = 2'h0;
	logic [7:0] adrs [5] = '{OFS_CORE_CTRL, OFS_FS_OVR, OFS_HS_OVR, OFS_OTG_CONTROL_STATUS, 8'h0C};
	logic [1:0] codes [4] = '{SPEED_HS, SPEED_FS, SPEED_LS, 2'h3};
	int n_mismatch = 0;
	int total_checks = 0;
	int since = 0;
	int f, g;

	eof1_point_select u_dut (
		.core_clk_i(clk), .reset_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .host_mode_i(hmode),
		.link_speed_i(spd), .tx_request_i(treq), .tx_allow_o(allow),
		.sof_o(sof), .eof1_reached_o(eof1)
	);

	always #2 clk = ~clk;
	always @(posedge clk) since <= (sof === 1'b1) ? 0 : since + 1;

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// called just after a rising edge; holds the request until ack or err is sampled
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q, output logic e);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
		chk("bus answer", 32'h1, {31'h0, ack | err});
		q = rdat;
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic [31:0] expect_rd(input logic [7:0] a);
		case (a)
			OFS_CORE_CTRL: return m40;
			OFS_FS_OVR: return m44;
			OFS_HS_OVR: return m48;
			OFS_OTG_CONTROL_STATUS: return {8'h00, m_spd, 22'h00_0000};
			default: return '0;
		endcase
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q, msk;
		logic e;
		msk = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		bus(a, 1'b1, d, s, q, e);
		case (a)
			OFS_CORE_CTRL: m40 = (m40 & ~msk | d & msk) & 32'h0000_000C;
			OFS_FS_OVR: m44 = (m44 & ~msk | d & msk) & 32'h0000_7FFF;
			OFS_HS_OVR: m48 = (m48 & ~msk | d & msk) & 32'h0000_0FFF;
			default: ;
		endcase
		chk("write err", {31'h0, a == 8'h0C}, {31'h0, e});
	endtask

	task automatic rd(input logic [7:0] a);
		logic [31:0] q;
		logic e;
		bus(a, 1'b0, '0, 4'hF, q, e);
		chk("read data", expect_rd(a), q);
		chk("read err", {31'h0, a == 8'h0C}, {31'h0, e});
	endtask

	// a level or pulse may take up to one hs frame (31250 cycles) plus margin to show up; an fs frame is longer than this limit
	task automatic wait_hi(input bit want_sof);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (((want_sof ? sof : eof1) !== 1'b1) && k < 40000);
		chk("event seen", 32'h1, {31'h0, k < 40000});
	endtask

	// registered flags may land one cycle after the count match
	task automatic chk_pt(input string nm, input int p);
		chk(nm, 32'(p), 32'(since + 1 - ((since == p) ? 1 : 0)));
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		end_sim;
	end

	initial begin
		void'($urandom(95));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (adrs[i]) rd(adrs[i]);
		repeat (3) foreach (adrs[i]) begin
			wr(adrs[i], $urandom, 4'($urandom));
			rd(adrs[i]);
		end
		foreach (codes[i]) begin
			spd <= codes[i];
			if (codes[i] != 2'h3)
				m_spd = codes[i];
			repeat (2) @(posedge clk);
			rd(OFS_OTG_CONTROL_STATUS);
		end
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		m40 = '0;
		m44 = '0;
		m48 = '0;
		m_spd = 2'h0;
		@(posedge clk);
		foreach (adrs[i]) rd(adrs[i]);
		spd <= SPEED_HS;
		wr(OFS_CORE_CTRL, 32'h0000_0008, 4'h1);
		wr(OFS_FRAME_CTRL, 32'h0000_0001, 4'h1);
		wait_hi(1'b1);
		wait_hi(1'b0);
		chk_pt("hs coarse point", HS_FRAME_CYC - HS_REF_2 * CLK_MHZ / REF_MHZ);
		chk("allow after point", '0, {31'h0, allow});
		f = $urandom_range(4095, 64);
		wr(OFS_HS_OVR, 32'(f), 4'h3);
		wait_hi(1'b1);
		chk("frame length", 32'(HS_FRAME_CYC), 32'(since + 1));
		wait_hi(1'b0);
		chk_pt("hs override point", f);
		chk("allow after point", '0, {31'h0, allow});
		wait_hi(1'b1);
		spd <= SPEED_FS;
		m_spd = SPEED_FS;
		g = $urandom_range(511, 64);
		wr(OFS_FS_OVR, 32'(g), 4'h3);
		chk("allow before point", 32'h1, {31'h0, allow});
		treq <= 1'b0;
		@(posedge clk);
		chk("allow without request", '0, {31'h0, allow});
		treq <= 1'b1;
		wait_hi(1'b0);
		chk_pt("fs override point", g);
		chk("allow after point", '0, {31'h0, allow});
		rd(OFS_OTG_CONTROL_STATUS);
		// leaving host mode must close the gate and pin the speed report at fs
		hmode <= 1'b0;
		spd <= SPEED_HS;
		repeat (2) @(posedge clk);
		chk("allow outside host", '0, {31'h0, allow});
		m_spd = SPEED_FS;
		rd(OFS_OTG_CONTROL_STATUS);
		end_sim;
	end
endmodule
